/* File: src/phy_10m_test_control_regs.sv */
// Extended 10 Mb/s control, driver test and soft-reset registers, one port.
// Assumes one AHB-Lite master, word transfers only, and a PHY core that
// consumes the decoded controls and supplies the line events.
//
// Contract
// - Serial mode bit routes 10 Mb/s paths through the serial interface, strap reset.
// - Three-bit squelch field resets to 100 and sets the squelch threshold.
// - Half-duplex 10 Mb/s echoes transmit to receive unless echo is disabled.
// - Link pulse off bit stops normal link pulses.
// - Force link bit reports a good 10 Mb/s link whatever the line does.
// - Heartbeat disable acts only in half-duplex 10 Mb/s, else heartbeat off.
// - Jabber disable turns jabber off, 10 Mb/s twisted pair only.
// - Error counter counts errored nibbles, clears on restart, saturates.
// - Continuous bit with self-test sends pseudo-random data with no break.
// - Pattern enable drives the chosen test pattern, else pattern off.
// - Gap bit sets 15 us between sequences when one, 10 us when zero.
// - Select 00 data end_of_packet_type0, 01 data end_of_packet_type1, 10 link pulses, 11 constant ones.
// - Soft reset resets all logic but the registers and clears itself.
// - Reserved bits of the second control register ignore writes, read zero.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module phy_10m_test_control_regs
  import phy10_regs_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Straps and PHY core status
  input wire logic strap_serial,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic line_link_ok,
  input wire logic polarity_inverted,
  input wire logic selftest_run,
  input wire logic selftest_nibble_err,
  // Controls to the PHY core
  output logic serial_network_iface,
  output logic [2:0] squelch_level,
  output logic echo_loop_en,
  output logic normal_link_pulse_en,
  output logic link_good_10m,
  output logic sqe_test_en,
  output logic long_tx_guard_en,
  output logic selftest_continuous,
  output logic core_reset,
  // Common-driver test pattern
  output logic driver_pattern_active,
  output logic [1:0] driver_pattern_kind,
  output logic driver_pattern_gap,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // Register index arithmetic
  // ----------------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [31:0] a);
    reg_index = a[9:2];
  endfunction : reg_index

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [15:0] ten_meg_status_control;
  logic [15:0] driver_test_selftest_ext;
  logic soft_reset_bit;
  logic [3:0] srst_cnt;
  logic polarity_latch;
  logic [7:0] selftest_nibble_errors;
  logic selftest_run_d;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic strap_pending;
  logic dp_active;
  logic dp_write;
  logic dp_read;
  logic [7:0] dp_index;
  pattern_state_t pg_state;
  pattern_state_t next_pg_state;
  logic [7:0] pg_cnt;

  // ----------------------------------------------------------------------
  // Bus: address phase capture, zero wait states
  // ----------------------------------------------------------------------
  wire addr_valid = hsel && hready && htrans[1];

  // Address phase registered for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_active <= 1'b0;
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_index <= 8'h00;
    end
    else if (hready)
    begin
      dp_active <= addr_valid;
      dp_write <= addr_valid && hwrite;
      dp_read <= addr_valid && !hwrite;
      dp_index <= reg_index(haddr);
    end
  end

  // Register decode in the data phase, one parallel compare per register
  wire wr_ten = dp_write && (dp_index == IDX_TEN_MEG);
  wire wr_drv = dp_write && (dp_index == IDX_DRV_TEST);
  wire wr_c2 = dp_write && (dp_index == IDX_CTRL2);
  wire wr_ist = dp_write && (dp_index == IDX_IRQ_STATUS);
  wire wr_imk = dp_write && (dp_index == IDX_IRQ_MASK);
  wire rd_ten = dp_read && (dp_index == IDX_TEN_MEG);

  // Read values with live fields
  wire [15:0] ten_rd = (ten_meg_status_control & TEN_MEG_WMASK)
                     | (16'(polarity_latch) << B_POLARITY);
  wire [15:0] drv_rd = {selftest_nibble_errors,
                        driver_test_selftest_ext[7:0]};
  wire [15:0] c2_rd = 16'(soft_reset_bit) << B_SOFT_RST;
  wire [15:0] phy_status_register_rd = 16'(polarity_latch) << B_PHY_STATUS_REGISTER_POL;

  // Read mux; unmapped words read zero
  logic [15:0] rd_mux;
  always_comb
  begin
    if (dp_index == IDX_TEN_MEG)
      rd_mux = ten_rd;
    else if (dp_index == IDX_DRV_TEST)
      rd_mux = drv_rd;
    else if (dp_index == IDX_CTRL2)
      rd_mux = c2_rd;
    else if (dp_index == IDX_IRQ_STATUS)
      rd_mux = 16'(irq_status);
    else if (dp_index == IDX_IRQ_MASK)
      rd_mux = 16'(irq_mask);
    else if (dp_index == IDX_PHY_STATUS)
      rd_mux = phy_status_register_rd;
    else
      rd_mux = 16'h0000;
  end

  assign hrdata = dp_read ? {16'h0000, rd_mux} : 32'h0000_0000;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------------
  // 10 Mb/s status/control register
  // ----------------------------------------------------------------------
  // Strap is caught by a clocked load after reset release, not by the reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ten_meg_status_control <= TEN_MEG_RESET;
      strap_pending <= 1'b1;
    end
    else if (strap_pending)
    begin
      ten_meg_status_control[B_SERIAL] <= strap_serial;
      strap_pending <= 1'b0;
    end
    else if (wr_ten)
      ten_meg_status_control <= hwdata[15:0] & TEN_MEG_WMASK;
  end

  // Polarity latch: a new event wins over the clearing read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      polarity_latch <= 1'b0;
    else if (polarity_inverted)
      polarity_latch <= 1'b1;
    else if (rd_ten)
      polarity_latch <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Driver test / self-test register
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      driver_test_selftest_ext <= DRV_TEST_RESET;
    else if (wr_drv)
      driver_test_selftest_ext <= hwdata[15:0] & DRV_TEST_WMASK;
  end

  // Error counter, restarted by a fresh self-test start or soft reset
  wire st_restart = selftest_run && !selftest_run_d;
  wire err_at_max = (selftest_nibble_errors == ERR_MAX);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      selftest_nibble_errors <= 8'h00;
      selftest_run_d <= 1'b0;
    end
    else
    begin
      selftest_run_d <= selftest_run;
      if (st_restart || core_reset)
        selftest_nibble_errors <= 8'h00;
      else if (selftest_run && selftest_nibble_err && !err_at_max)
        selftest_nibble_errors <= selftest_nibble_errors + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Second control register: self-clearing soft reset
  // ----------------------------------------------------------------------
  // Pulse held a few cycles so slow core logic sees it; settings kept, error count cleared
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      soft_reset_bit <= 1'b0;
      srst_cnt <= 4'h0;
    end
    else if (wr_c2 && hwdata[B_SOFT_RST])
    begin
      soft_reset_bit <= 1'b1;
      srst_cnt <= SRST_CYC;
    end
    else if (srst_cnt != 4'h0)
      srst_cnt <= srst_cnt - 4'h1;
    else
      soft_reset_bit <= 1'b0;
  end
  assign core_reset = soft_reset_bit;

  // ----------------------------------------------------------------------
  // Decoded controls to the core
  // ----------------------------------------------------------------------
  wire half_10m = !speed_100 && !full_duplex;
  assign serial_network_iface = ten_meg_status_control[B_SERIAL]
                              && !speed_100;
  assign squelch_level = ten_meg_status_control[B_SQ_HI:B_SQ_LO];
  assign echo_loop_en = half_10m
                      && !ten_meg_status_control[B_ECHO_DIS];
  assign normal_link_pulse_en = !ten_meg_status_control[B_LP_OFF]
                              && !core_reset;
  assign link_good_10m = ten_meg_status_control[B_FORCE_LINK]
                       || line_link_ok;
  assign sqe_test_en = half_10m
                     && !ten_meg_status_control[B_SQE_DIS];
  assign long_tx_guard_en = !speed_100
                          && !ten_meg_status_control[B_JAB_DIS];
  assign selftest_continuous = driver_test_selftest_ext[B_CONT]
                             && selftest_run;

  // ----------------------------------------------------------------------
  // Common-driver pattern sequencer: burst, then timed gap
  // ----------------------------------------------------------------------
  wire pat_en = driver_test_selftest_ext[B_PAT_EN] && !core_reset;
  wire [1:0] pat_sel = driver_test_selftest_ext[1:0];
  wire pat_tone = (pat_sel == PAT_TONE);
  wire [7:0] gap_len = driver_test_selftest_ext[B_GAP] ? GAP_LONG_CYC
                                                       : GAP_SHORT_CYC;
  wire pg_done = (pg_cnt == 8'h00);

  // Next state; the tone pattern never pauses
  always_comb
  begin
    next_pg_state = pg_state;
    case (pg_state)
      PG_OFF:
        if (pat_en)
          next_pg_state = PG_SEND;
      PG_SEND:
        if (!pat_en)
          next_pg_state = PG_OFF;
        else if (pg_done && !pat_tone)
          next_pg_state = PG_GAP;
      PG_GAP:
        if (!pat_en)
          next_pg_state = PG_OFF;
        else if (pg_done)
          next_pg_state = PG_SEND;
      default:
        next_pg_state = PG_OFF;
    endcase
  end

  // State and the shared burst/gap counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pg_state <= PG_OFF;
      pg_cnt <= 8'h00;
    end
    else
    begin
      pg_state <= next_pg_state;
      if (next_pg_state != pg_state)
        pg_cnt <= (next_pg_state == PG_GAP) ? gap_len - 8'h01
                                            : PATTERN_BURST_CYC - 8'h01;
      else if (!pg_done)
        pg_cnt <= pg_cnt - 8'h01;
    end
  end

  // Registered pattern outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      driver_pattern_active <= 1'b0;
      driver_pattern_kind <= 2'b00;
      driver_pattern_gap <= 1'b0;
    end
    else
    begin
      driver_pattern_active <= (next_pg_state == PG_SEND);
      driver_pattern_kind <= pat_sel;
      driver_pattern_gap <= (next_pg_state == PG_GAP);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // ----------------------------------------------------------------------
  logic err_at_max_d;
  wire [IRQ_W-1:0] irq_set = {wr_c2 && hwdata[B_SOFT_RST],
                              err_at_max && !err_at_max_d,
                              polarity_inverted};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status <= '0;
      irq_mask <= '0;
      err_at_max_d <= 1'b0;
    end
    else
    begin
      err_at_max_d <= err_at_max;
      irq_status <= (irq_status & ~(wr_ist ? hwdata[IRQ_W-1:0] : '0))
                  | irq_set;
      if (wr_imk)
        irq_mask <= hwdata[IRQ_W-1:0];
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_SQUELCH_FIELD: assert property (
    wr_ten |=> squelch_level == $past(hwdata[B_SQ_HI:B_SQ_LO]))
    else $error("squelch level differs from its field");
  AST_ECHO_HALF: assert property (
    (speed_100 || full_duplex) |-> !echo_loop_en)
    else $error("echo active outside half-duplex 10M");
  AST_FORCE_LINK: assert property (
    ten_meg_status_control[B_FORCE_LINK] |-> link_good_10m)
    else $error("forced link not reported");
  AST_POL_SET: assert property (
    polarity_inverted |=> polarity_latch)
    else $error("polarity not latched");
  AST_POL_CLR: assert property (
    (rd_ten && !polarity_inverted) |=> !polarity_latch)
    else $error("polarity not cleared by read");
  AST_SQE_FULL: assert property (
    full_duplex |-> !sqe_test_en)
    else $error("heartbeat on in full duplex");
  AST_ERR_SAT: assert property (
    (err_at_max && !st_restart && !core_reset) |=> err_at_max)
    else $error("error counter wrapped");
  AST_SRST_LEN: assert property (
    (wr_c2 && hwdata[B_SOFT_RST]) |=> core_reset [*5] ##1 !core_reset)
    else $error("soft reset pulse length wrong");
  AST_C2_RSVD: assert property (
    (dp_read && (dp_index == IDX_CTRL2))
      |-> (hrdata & ~(32'h0000_0001 << B_SOFT_RST)) == 32'h0000_0000)
    else $error("reserved control bits read non-zero");
  AST_PAT_OFF: assert property (
    !driver_test_selftest_ext[B_PAT_EN] |=> !driver_pattern_active)
    else $error("pattern active while disabled");

  COV_SRST: cover property (wr_c2 && hwdata[B_SOFT_RST]);
  COV_SAT: cover property (err_at_max && selftest_nibble_err);
  COV_GAP: cover property (pg_state == PG_GAP ##1 pg_state == PG_SEND);
  COV_IRQ: cover property (irq);

endmodule : phy_10m_test_control_regs

/* File: src/phy10_regs_pkg.sv */
// Package for the 10 Mb/s control, driver test and second control registers.
// Assumes a single AHB-Lite slave with 32-bit data, one word per register.
package phy10_regs_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (printed offsets are indices, byte address = 4*index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_TEN_MEG = 8'h1A;
  localparam logic [7:0] IDX_DRV_TEST = 8'h1B;
  localparam logic [7:0] IDX_CTRL2 = 8'h1C;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] IDX_PHY_STATUS = 8'h22;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int B_SERIAL = 15;
  localparam int B_SQ_HI = 11;
  localparam int B_SQ_LO = 9;
  localparam int B_ECHO_DIS = 8;
  localparam int B_LP_OFF = 7;
  localparam int B_FORCE_LINK = 6;
  localparam int B_POLARITY = 4;
  localparam int B_SQE_DIS = 1;
  localparam int B_JAB_DIS = 0;
  localparam int B_ERR_HI = 15;
  localparam int B_ERR_LO = 8;
  localparam int B_CONT = 5;
  localparam int B_PAT_EN = 4;
  localparam int B_GAP = 2;
  localparam int B_SOFT_RST = 9;
  localparam int B_PHY_STATUS_REGISTER_POL = 12;

  // Writable masks of the mixed registers
  localparam logic [15:0] TEN_MEG_WMASK = 16'hFFEF;
  localparam logic [15:0] DRV_TEST_WMASK = 16'h00FF;
  localparam logic [15:0] TEN_MEG_RESET = 16'h0804;
  localparam logic [15:0] DRV_TEST_RESET = 16'h0000;
  localparam logic [7:0] ERR_MAX = 8'hFF;

  // Interrupt status bits
  localparam int IRQ_POL = 0;
  localparam int IRQ_ERRSAT = 1;
  localparam int IRQ_SRST = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------------
  // Timing: pattern gaps and soft-reset pulse length
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int GAP_LONG_US = 15;
  localparam int GAP_SHORT_US = 10;
  localparam logic [7:0] GAP_LONG_CYC = 8'(GAP_LONG_US * CLK_MHZ);
  localparam logic [7:0] GAP_SHORT_CYC = 8'(GAP_SHORT_US * CLK_MHZ);
  localparam logic [7:0] PATTERN_BURST_CYC = 8'h10;
  localparam logic [3:0] SRST_CYC = 4'h4;

  // Pattern select codes
  typedef enum logic [1:0] {
    PAT_END_OF_PACKET_TYPE0 = 2'b00,
    PAT_END_OF_PACKET_TYPE1 = 2'b01,
    PAT_LINK_PULSE = 2'b10,
    PAT_TONE = 2'b11
  } pattern_sel_t;

  // Pattern generator states
  typedef enum logic [1:0] {
    PG_OFF = 2'b00,
    PG_SEND = 2'b01,
    PG_GAP = 2'b10
  } pattern_state_t;

endpackage : phy10_regs_pkg

/* File: verif/phy_core_model.sv */
// Stand-in for the PHY core around the register block: strap, speed,
// duplex, line link, polarity events and packet self-test activity.
// Assumes the bench calls its tasks from one process, between edges.
`timescale 1ns/1ps

module phy_core_model
(
  // Clock
  input wire logic hclk,
  // Strap and core status towards the block
  output logic strap_serial,
  output logic speed_100,
  output logic full_duplex,
  output logic line_link_ok,
  output logic polarity_inverted,
  output logic selftest_run,
  output logic selftest_nibble_err
);
  // ----------------------------------------------------------------------
  // Power-up levels
  // ----------------------------------------------------------------------
  // Strap high so the serial default is visibly loaded
  initial
  begin
    strap_serial = 1'b1;
    speed_100 = 1'b0;
    full_duplex = 1'b0;
    line_link_ok = 1'b0;
    polarity_inverted = 1'b0;
    selftest_run = 1'b0;
    selftest_nibble_err = 1'b0;
  end

  // Speed, duplex and line link change just after an edge
  task automatic set_mode(input logic s, input logic f, input logic l);
    @(posedge hclk);
    speed_100 <= s;
    full_duplex <= f;
    line_link_ok <= l;
  endtask : set_mode

  // One-cycle inverted polarity detection
  task automatic pol_event();
    @(posedge hclk);
    polarity_inverted <= 1'b1;
    @(posedge hclk);
    polarity_inverted <= 1'b0;
  endtask : pol_event

  // Self-test restart: run drops for a cycle then rises again
  task automatic restart();
    @(posedge hclk);
    selftest_run <= 1'b0;
    @(posedge hclk);
    selftest_run <= 1'b1;
  endtask : restart

  // A run of n errored nibbles, one per cycle
  task automatic errs(input int n);
    @(posedge hclk);
    selftest_nibble_err <= 1'b1;
    repeat (n) @(posedge hclk);
    selftest_nibble_err <= 1'b0;
  endtask : errs
endmodule : phy_core_model

/* File: verif/phy_10m_test_control_regs_tb.sv */
// Self-checking bench for the 10 Mb/s control and driver test registers.
// Assumes zero-wait AHB-Lite slave; read data checked from a queue.
`timescale 1ns/1ps

module phy_10m_test_control_regs_tb;
  import phy10_regs_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, rd_pend = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, seed = 32'h00000E94;
  logic [1:0] htrans, driver_pattern_kind;
  logic [2:0] hsize, squelch_level;
  logic strap_serial, speed_100, full_duplex, line_link_ok;
  logic polarity_inverted, selftest_run, selftest_nibble_err;
  logic serial_network_iface, echo_loop_en, normal_link_pulse_en;
  logic link_good_10m, sqe_test_en, long_tx_guard_en, selftest_continuous;
  logic core_reset, driver_pattern_active, driver_pattern_gap, irq;
  logic [15:0] cfg;
  logic [8:0] ctl;
  int num_errors = 0, total_checks = 0, cyc = 0, n;
  logic [31:0] expq[$];

  always #50 hclk = ~hclk;

  phy_10m_test_control_regs DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .strap_serial(strap_serial),
    .speed_100(speed_100), .full_duplex(full_duplex),
    .line_link_ok(line_link_ok), .polarity_inverted(polarity_inverted),
    .selftest_run(selftest_run), .selftest_nibble_err(selftest_nibble_err),
    .serial_network_iface(serial_network_iface),
    .squelch_level(squelch_level), .echo_loop_en(echo_loop_en),
    .normal_link_pulse_en(normal_link_pulse_en),
    .link_good_10m(link_good_10m), .sqe_test_en(sqe_test_en),
    .long_tx_guard_en(long_tx_guard_en),
    .selftest_continuous(selftest_continuous), .core_reset(core_reset),
    .driver_pattern_active(driver_pattern_active),
    .driver_pattern_kind(driver_pattern_kind),
    .driver_pattern_gap(driver_pattern_gap), .irq(irq));

  phy_core_model core (.hclk(hclk), .strap_serial(strap_serial),
    .speed_100(speed_100), .full_duplex(full_duplex),
    .line_link_ok(line_link_ok), .polarity_inverted(polarity_inverted),
    .selftest_run(selftest_run), .selftest_nibble_err(selftest_nibble_err));

  // ----------------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Hang guard, well above the thousand or so cycles the tests need
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      complete_run();
    end
  end

  // Read data taken at the edge that ends its data phase, as a master would
  always @(posedge hclk)
  begin
    if (rd_pend === 1'b1)
      cmp(hrdata, expq.size() ? expq.pop_front() : 32'hDEADBEEF);
    rd_pend <= hsel & hreadyout & htrans[1] & ~hwrite;
  end

  // ----------------------------------------------------------------------
  // Bus master and stimulus helpers
  // ----------------------------------------------------------------------
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expq.push_back(e);
    ahb(1'b0, a, 32'h00000000);
  endtask : rd

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    // Reset values, strap loaded, unmapped word reads zero
    rd(32'h68, 32'h00008804);
    rd(32'h6C, 32'h00000000);
    rd(32'h70, 32'h00000000);
    rd(32'h00, 32'h00000000);
    cmp(32'(hresp), 32'h0);
    $display("test reset_values done");
    // Random settings under every speed and duplex pairing
    for (int m = 0; m < 4; m++)
    begin
      core.set_mode(m[1], m[0], m[0]);
      // Read-only polarity bit 4 kept out, it never takes a written value
      cfg = 16'(xs() & 32'h00008FC7) | 16'h0004;
      wr(32'h68, 32'(cfg));
      rd(32'h68, 32'(cfg));
      @(negedge hclk);
      ctl = {cfg[15] & ~m[1], cfg[11:9], ~m[1] & ~m[0] & ~cfg[8], ~cfg[7],
             cfg[6] | m[0], ~m[1] & ~m[0] & ~cfg[1], ~m[1] & ~cfg[0]};
      cmp(32'({serial_network_iface, squelch_level, echo_loop_en,
               normal_link_pulse_en, link_good_10m, sqe_test_en,
               long_tx_guard_en}), 32'(ctl));
    end
    core.set_mode(1'b0, 1'b0, 1'b0);
    $display("test config_modes done");
    // Polarity latch, mirror, clear on read here only; interrupt path
    wr(32'h84, 32'h00000001);
    core.pol_event();
    @(negedge hclk);
    cmp(32'(irq), 32'h1);
    rd(32'h88, 32'h00001000);
    rd(32'h88, 32'h00001000);
    rd(32'h68, 32'(cfg | 16'h0010));
    rd(32'h68, 32'(cfg));
    rd(32'h88, 32'h00000000);
    wr(32'h80, 32'h00000001);
    @(negedge hclk);
    cmp(32'(irq), 32'h0);
    $display("test polarity done");
    // Error counter: saturation, restart clear, masked then unmasked irq
    core.restart();
    core.errs(300);
    rd(32'h6C, 32'h0000FF00);
    rd(32'h80, 32'h00000002);
    cmp(32'(irq), 32'h0);
    wr(32'h84, 32'h00000003);
    @(negedge hclk);
    cmp(32'(irq), 32'h1);
    wr(32'h80, 32'h00000002);
    core.restart();
    rd(32'h6C, 32'h00000000);
    core.errs(5);
    wr(32'h68, 32'(cfg | 16'h0001));
    wr(32'h6C, 32'h00000020);
    rd(32'h6C, 32'h00000520);
    @(negedge hclk);
    cmp(32'({irq, selftest_continuous}), 32'h1);
    $display("test selftest done");
    // Every pattern code, both gap lengths, off between settings
    for (int k = 0; k < 4; k++)
    begin
      wr(32'h6C, {27'h0000000, 1'b1, 1'b0, ~k[0], k[1:0]});
      wait (driver_pattern_active === 1'b1);
      cmp(32'(driver_pattern_kind), 32'(k));
      n = 0;
      if (k < 3)
      begin
        while (driver_pattern_gap !== 1'b1) @(negedge hclk);
        while (driver_pattern_gap === 1'b1)
        begin
          n++;
          @(negedge hclk);
        end
        cmp(32'(n), k[0] ? 32'd100 : 32'd150);
      end
      else
      begin
        repeat (200) @(negedge hclk) n += driver_pattern_active;
        cmp(32'(n), 32'd200);
      end
      wr(32'h6C, 32'h00000000);
      repeat (2) @(negedge hclk);
      cmp(32'(driver_pattern_active), 32'h0);
    end
    $display("test patterns done");
    // Soft reset: pulse length, self-clear, configuration kept
    wr(32'h70, 32'h0000FFFF);
    fork
      begin
        n = 0;
        while (core_reset !== 1'b1 && n < 4)
        begin
          n++;
          @(negedge hclk);
        end
        n = 0;
        while (core_reset === 1'b1)
        begin
          n++;
          @(negedge hclk);
        end
      end
      rd(32'h70, 32'h00000200);
    join
    cmp(32'(n), 32'd5);
    rd(32'h70, 32'h00000000);
    rd(32'h68, 32'(cfg | 16'h0001));
    rd(32'h80, 32'h00000004);
    $display("test soft_reset done");
    complete_run();
  end
endmodule : phy_10m_test_control_regs_tb
